/* File: logic/sfg_map.vh */
`ifndef SFG_MAP_VH
`define SFG_MAP_VH

// Register byte offsets on the APB bus.
`define SFG_OFS_CTRL 8'h00
`define SFG_OFS_LOCK 8'h04
`define SFG_OFS_FUSE 8'h08

// Field positions inside store_program_control.
`define SFG_BIT_IE 7
`define SFG_BIT_BUSY 6
`define SFG_BIT_RSVD 5
`define SFG_CMD_MSB 4

// Reset value of store_program_control and its command field.
`define SFG_CTRL_RST 8'h00
`define SFG_CMD_IDLE 5'h00

// Command patterns of the low five bits.
`define SFG_CMD_REENABLE 5'h11
`define SFG_CMD_LOCKSET 5'h09
`define SFG_CMD_PGWRITE 5'h05
`define SFG_CMD_PGERASE 5'h03
`define SFG_CMD_PGLOAD 5'h01

// Lock fields after chip erase: all bits unprogrammed.
`define SFG_LOCK_ERASED 4'hf
// Position of the lock bits inside the low data byte of a lock-set store.
`define SFG_LOCK_DATA_LSB 2

// Byte address where the loader section starts, and where the halting section starts.
`define SFG_LOADER_START 14'h3800
`define SFG_HALT_START 14'h3800
// Application reset vector (word address).
`define SFG_APP_VECTOR 13'h0000

// Store arming window in clock cycles.
`define SFG_ARM_WINDOW 3'h4
// Default length of a page erase or page write in clock cycles.
`define SFG_PROG_CYCLES 16'h0028

`endif

/* File: logic/sfg_lock_decode.v */
`timescale 1ns/1ns
`default_nettype none

// Decodes one two-bit lock field into the three kinds of restriction it imposes.
module sfg_lock_decode (
  // Lock field bits, 1 means unprogrammed.
  input wire lock_hi,
  input wire lock_lo,
  // Decoded restrictions.
  output wire store_block,
  output wire load_block,
  output wire irq_block
);

  // Mode 1 (11) leaves every output low, so the section is unrestricted.
  // Modes 2 (10) and 3 (00) have the low bit programmed and forbid stores.
  assign store_block = ~lock_lo;
  // Modes 3 (00) and 4 (01) have the high bit programmed and forbid cross-section loads.
  assign load_block = ~lock_hi;
  // The same modes suppress interrupts when vectors sit in the other section.
  assign irq_block = ~lock_hi;

endmodule // sfg_lock_decode

`default_nettype wire

/* File: logic/sfg_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "sfg_map.vh"

module sfg_top #(
  // Length of a page erase or page write, in clock cycles.
  parameter [15:0] PROG_CYCLES = `SFG_PROG_CYCLES
) (
  // Clock and synchronous active-low reset.
  input wire clk,
  input wire rst_b,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Processor core, same clock.
  input wire [13:0] core_pc,
  input wire core_store,
  input wire [13:0] core_store_addr,
  input wire [15:0] core_store_data,
  input wire core_load,
  input wire [13:0] core_load_addr,
  input wire core_gie,
  input wire core_vec_in_loader,
  // Results to the core.
  output reg store_done_r,
  output reg store_refused_r,
  output reg load_grant_r,
  output reg load_refused_r,
  output reg cpu_halt_r,
  output reg irq_req_r,
  output reg irq_suppress_r,
  output reg [12:0] reset_vector_r,
  // Flash array and page buffer strobes.
  output reg page_erase_r,
  output reg page_write_r,
  output reg [13:0] page_addr_r,
  output reg pbuf_load_r,
  output reg pbuf_discard_r,
  output reg concurrent_section_busy_r,
  // External programming interface pins, asynchronous.
  input wire ext_lock_we,
  input wire [3:0] ext_lock_data,
  input wire ext_chip_erase,
  input wire ext_loader_reset_fuse
);

  // One-hot sequencer states.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_PROG = 3'b100;

  reg [2:0] state_r; // Sequencer state.
  reg [4:0] cmd_r; // Low five control bits; bit 0 is store_enable.
  reg store_ready_irq_enable_r; // Control bit 7.
  reg [2:0] win_cnt_r; // Cycles left in the arming window.
  reg [15:0] prog_cnt_r; // Cycles left in a page erase or write.
  reg pbuf_loaded_r; // The page buffer holds at least one loaded word.
  reg [3:0] lock_r; // {loader_lock_hi, loader_lock_lo, app_lock_hi, app_lock_lo}.
  reg fuse_cap_r; // Set once the reset vector has been captured.
  // Two-stage synchronisers for the programming pins, plus edge history.
  reg ext_we_s1_r, ext_we_s2_r, ext_we_d_r;
  reg ext_ce_s1_r, ext_ce_s2_r, ext_ce_d_r;
  reg [3:0] ext_data_s1_r, ext_data_s2_r;
  reg fuse_s1_r, fuse_s2_r;

  wire store_enable = cmd_r[0];
  wire apb_setup = psel & penable & ~pready;
  wire apb_wr = psel & penable & pready & pwrite;
  // Section of the running code and of each target address.
  wire pc_in_loader = core_pc >= `SFG_LOADER_START;
  wire st_in_loader = core_store_addr >= `SFG_LOADER_START;
  wire ld_in_loader = core_load_addr >= `SFG_LOADER_START;
  wire st_in_halt = core_store_addr >= `SFG_HALT_START;
  wire ld_in_halt = core_load_addr >= `SFG_HALT_START;
  // A write that carries one of the five legal command patterns.
  wire [4:0] wr_cmd = pwdata[`SFG_CMD_MSB:0];
  wire cmd_legal = (wr_cmd == `SFG_CMD_REENABLE) | (wr_cmd == `SFG_CMD_LOCKSET) |
                   (wr_cmd == `SFG_CMD_PGWRITE) | (wr_cmd == `SFG_CMD_PGERASE) |
                   (wr_cmd == `SFG_CMD_PGLOAD);

  // Per-section decoded restrictions: index 0 application, index 1 loader.
  wire [1:0] blk_store;
  wire [1:0] blk_load;
  wire [1:0] blk_irq;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lock
      sfg_lock_decode u_dec (
        .lock_hi(lock_r[2 * gi + 1]),
        .lock_lo(lock_r[2 * gi]),
        .store_block(blk_store[gi]),
        .load_block(blk_load[gi]),
        .irq_block(blk_irq[gi])
      );
    end
  endgenerate

  // The general memory lock levels are not an input here at all, so they cannot gate stores or loads.
  // Store target restriction, and load restriction only when code reads the other section.
  wire st_blocked = st_in_loader ? blk_store[1] : blk_store[0];
  wire ld_cross = ld_in_loader != pc_in_loader;
  wire ld_blocked = ld_cross & (ld_in_loader ? blk_load[1] : blk_load[0]);
  // Loads into the concurrent section are refused while it is busy.
  wire ld_busy = concurrent_section_busy_r & ~ld_in_halt;
  wire [13:0] loader_vec_word = `SFG_LOADER_START >> 1; // Loader start as a word address.

  // Synchronisers: only the second stage feeds any logic.
  // The fuse pair runs through reset, so a programmed fuse has settled by the time reset ends.
  always @(posedge clk) begin
    fuse_s1_r <= ext_loader_reset_fuse;
    fuse_s2_r <= fuse_s1_r;
    if (!rst_b) begin
      ext_we_s1_r <= 1'b0;
      ext_we_s2_r <= 1'b0;
      ext_we_d_r <= 1'b0;
      ext_ce_s1_r <= 1'b0;
      ext_ce_s2_r <= 1'b0;
      ext_ce_d_r <= 1'b0;
      ext_data_s1_r <= 4'h0;
      ext_data_s2_r <= 4'h0;
    end else begin
      ext_we_s1_r <= ext_lock_we;
      ext_we_s2_r <= ext_we_s1_r;
      ext_we_d_r <= ext_we_s2_r;
      ext_ce_s1_r <= ext_chip_erase;
      ext_ce_s2_r <= ext_ce_s1_r;
      ext_ce_d_r <= ext_ce_s2_r;
      ext_data_s1_r <= ext_lock_data;
      ext_data_s2_r <= ext_data_s1_r;
    end
  end

  // Reset vector: caught from the synchronised fuse once after reset release.
  // The processor has no path to the fuse; only the external pin moves it.
  always @(posedge clk) begin
    if (!rst_b) begin
      reset_vector_r <= `SFG_APP_VECTOR;
      fuse_cap_r <= 1'b0;
    end else if (!fuse_cap_r) begin
      // Unprogrammed fuse (1) starts at zero, programmed (0) at the loader.
      reset_vector_r <= fuse_s2_r ? `SFG_APP_VECTOR : loader_vec_word[12:0];
      fuse_cap_r <= 1'b1;
    end
  end

  // APB slave: one wait state, read data and error prepared for the answer cycle.
  always @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr)
          // Bit 5 is reserved and always reads zero.
          `SFG_OFS_CTRL: prdata <= {24'h00_0000, store_ready_irq_enable_r, concurrent_section_busy_r, 1'b0, cmd_r};
          `SFG_OFS_LOCK: prdata <= {28'h000_0000, lock_r};
          `SFG_OFS_FUSE: prdata <= {31'h0000_0000, fuse_s2_r};
          // Unmapped offsets answer with an error and zero data.
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Interrupt outputs, refreshed every cycle.
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_req_r <= 1'b0;
      irq_suppress_r <= 1'b0;
    end else begin
      // Ready interrupt stays requested while store_enable is clear.
      irq_req_r <= store_ready_irq_enable_r & core_gie & ~store_enable;
      // Vectors in one section, code in the other, and that section's field forbids it.
      irq_suppress_r <= (blk_irq[0] & core_vec_in_loader & ~pc_in_loader) |
                        (blk_irq[1] & ~core_vec_in_loader & pc_in_loader);
    end
  end

  // Load checking: one answer per load pulse, one cycle later.
  always @(posedge clk) begin
    if (!rst_b) begin
      load_grant_r <= 1'b0;
      load_refused_r <= 1'b0;
    end else begin
      load_grant_r <= core_load & ~ld_blocked & ~ld_busy;
      load_refused_r <= core_load & (ld_blocked | ld_busy);
    end
  end

  // Lock fields: bits may only go from 1 to 0, except on chip erase and reset.
  always @(posedge clk) begin
    if (!rst_b) begin
      lock_r <= `SFG_LOCK_ERASED;
    end else if (ext_ce_s2_r & ~ext_ce_d_r) begin
      lock_r <= `SFG_LOCK_ERASED;
    end else begin
      if (ext_we_s2_r & ~ext_we_d_r) begin
        lock_r <= lock_r & ext_data_s2_r;
      end else if (state_r == ST_ARMED && core_store && cmd_r == `SFG_CMD_LOCKSET && pc_in_loader) begin
        lock_r <= lock_r & core_store_data[`SFG_LOCK_DATA_LSB + 3:`SFG_LOCK_DATA_LSB];
      end
    end
  end

  // Command sequencer: arming window, store execution, erase and write timing.
  always @(posedge clk) begin
    if (!rst_b) begin
      // Every writable control bit starts at zero.
      state_r <= ST_IDLE;
      cmd_r <= `SFG_CMD_IDLE;
      store_ready_irq_enable_r <= 1'b0;
      concurrent_section_busy_r <= 1'b0;
      win_cnt_r <= 3'h0;
      prog_cnt_r <= 16'h0000;
      pbuf_loaded_r <= 1'b0;
      cpu_halt_r <= 1'b0;
      store_done_r <= 1'b0;
      store_refused_r <= 1'b0;
      page_erase_r <= 1'b0;
      page_write_r <= 1'b0;
      page_addr_r <= 14'h0000;
      pbuf_load_r <= 1'b0;
      pbuf_discard_r <= 1'b0;
    end else begin
      // Pulses default low.
      store_done_r <= 1'b0;
      store_refused_r <= 1'b0;
      page_erase_r <= 1'b0;
      page_write_r <= 1'b0;
      pbuf_load_r <= 1'b0;
      pbuf_discard_r <= 1'b0;
      // Interrupt enable is always writable, even during an operation.
      if (apb_wr && paddr == `SFG_OFS_CTRL) begin
        store_ready_irq_enable_r <= pwdata[`SFG_BIT_IE];
      end
      case (state_r)
        ST_IDLE: begin
          // Only legal patterns arm the store; anything else leaves the command bits alone.
          // Writes while store_enable is set never reach here, so a re-enable cannot cut an operation short.
          if (apb_wr && paddr == `SFG_OFS_CTRL && cmd_legal) begin
            cmd_r <= wr_cmd;
            win_cnt_r <= `SFG_ARM_WINDOW;
            state_r <= ST_ARMED;
            // A re-enable during buffer loading throws the buffer away.
            if (wr_cmd == `SFG_CMD_REENABLE && pbuf_loaded_r) begin
              pbuf_discard_r <= 1'b1;
              pbuf_loaded_r <= 1'b0;
            end
          end
        end
        ST_ARMED: begin
          if (core_store) begin
            if (!pc_in_loader) begin
              // Stores from application code are never executed.
              store_refused_r <= 1'b1;
              cmd_r <= `SFG_CMD_IDLE;
              state_r <= ST_IDLE;
            end else begin
              case (cmd_r)
                `SFG_CMD_REENABLE: begin
                  // Store within the window re-opens the concurrent section.
                  concurrent_section_busy_r <= 1'b0;
                  store_done_r <= 1'b1;
                  cmd_r <= `SFG_CMD_IDLE;
                  state_r <= ST_IDLE;
                end
                `SFG_CMD_PGLOAD: begin
                  // A page-buffer load clears the busy flag on its own.
                  concurrent_section_busy_r <= 1'b0;
                  pbuf_load_r <= 1'b1;
                  pbuf_loaded_r <= 1'b1;
                  page_addr_r <= core_store_addr;
                  store_done_r <= 1'b1;
                  cmd_r <= `SFG_CMD_IDLE;
                  state_r <= ST_IDLE;
                end
                `SFG_CMD_PGERASE, `SFG_CMD_PGWRITE: begin
                  if (st_blocked) begin
                    // Locked target: flash is left untouched.
                    store_refused_r <= 1'b1;
                    cmd_r <= `SFG_CMD_IDLE;
                    state_r <= ST_IDLE;
                  end else begin
                    page_erase_r <= cmd_r == `SFG_CMD_PGERASE;
                    page_write_r <= cmd_r == `SFG_CMD_PGWRITE;
                    page_addr_r <= core_store_addr;
                    prog_cnt_r <= PROG_CYCLES;
                    // Halting section stalls the processor, otherwise the concurrent section goes busy.
                    cpu_halt_r <= st_in_halt;
                    concurrent_section_busy_r <= concurrent_section_busy_r | ~st_in_halt;
                    state_r <= ST_PROG;
                  end
                end
                default: begin
                  // Lock-set: the field update happens in the lock process.
                  store_done_r <= 1'b1;
                  cmd_r <= `SFG_CMD_IDLE;
                  state_r <= ST_IDLE;
                end
              endcase
            end
          end else if (win_cnt_r == 3'h1) begin
            // No store in the window: the command lapses.
            cmd_r <= `SFG_CMD_IDLE;
            state_r <= ST_IDLE;
          end else begin
            win_cnt_r <= win_cnt_r - 3'h1;
          end
        end
        ST_PROG: begin
          // store_enable stays set until the erase or write finishes.
          if (prog_cnt_r == 16'h0001) begin
            store_done_r <= 1'b1;
            cpu_halt_r <= 1'b0;
            // A finished page write empties the buffer.
            if (cmd_r == `SFG_CMD_PGWRITE) begin
              pbuf_loaded_r <= 1'b0;
            end
            cmd_r <= `SFG_CMD_IDLE;
            state_r <= ST_IDLE;
          end else begin
            prog_cnt_r <= prog_cnt_r - 16'h0001;
          end
        end
        default: begin
          // Unreachable codes fall back to idle.
          cmd_r <= `SFG_CMD_IDLE;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sfg_top

`default_nettype wire

/* File: verification/sfg_props.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checker for the flash guard; it judges only what the guard drives.
module sfg_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side.
  input wire logic [13:0] core_pc,
  input wire logic core_store,
  input wire logic core_load,
  input wire logic [13:0] core_load_addr,
  input wire logic store_refused_r,
  input wire logic load_grant_r,
  input wire logic load_refused_r,
  input wire logic cpu_halt_r,
  // Flash strobes.
  input wire logic page_erase_r,
  input wire logic page_write_r,
  input wire logic [13:0] page_addr_r,
  input wire logic pbuf_load_r,
  input wire logic concurrent_section_busy_r
);
  // Everything here lives in the one clock domain.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A single wait state keeps the master's hold time short and fixed.
  a_apb_wait_state: assert property (psel && penable && !pready |=> pready) else $error("answer late");
  a_apb_one_cycle: assert property (pready |=> !pready) else $error("answer held too long");
  a_unmapped_err: assert property (pready && paddr > 8'h08 |-> pslverr) else $error("unmapped not flagged");
  a_reserved_zero: assert property (pready && !pwrite && paddr == 8'h00 |-> !prdata[5])
    else $error("bit 5 set");
  a_load_answer: assert property (core_load |=> load_grant_r != load_refused_r)
    else $error("load unanswered");
  a_load_cause: assert property (load_grant_r || load_refused_r |-> $past(core_load))
    else $error("stray answer");
  a_busy_blocks: assert property (core_load && concurrent_section_busy_r && core_load_addr < 14'h3800
    |=> load_refused_r) else $error("busy section read");
  a_app_store_void: assert property (core_store && core_pc < 14'h3800
    |=> !(page_erase_r || page_write_r || pbuf_load_r)) else $error("store from app acted");
  a_refused_quiet: assert property (store_refused_r |-> !(page_erase_r || page_write_r || pbuf_load_r))
    else $error("refused store acted");
  a_erase_busy: assert property ((page_erase_r || page_write_r) && page_addr_r < 14'h3800
    |-> ##[0:1] concurrent_section_busy_r) else $error("busy not set");
  a_halt_core: assert property ((page_erase_r || page_write_r) && page_addr_r >= 14'h3800
    |-> ##[0:1] cpu_halt_r) else $error("core not halted");
  // Main scenarios reached.
  c_erase: cover property (page_erase_r);
  c_load_refused: cover property (load_refused_r);
  c_halt: cover property (cpu_halt_r);
endmodule // sfg_props

bind sfg_top sfg_props u_props (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .core_pc, .core_store, .core_load, .core_load_addr, .store_refused_r, .load_grant_r, .load_refused_r,
  .cpu_halt_r, .page_erase_r, .page_write_r, .page_addr_r, .pbuf_load_r, .concurrent_section_busy_r);
`default_nettype wire

/* File: verification/sfg_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Behavioural processor core issuing store and load instructions.
module sfg_core_model (
  // Clock.
  input wire logic clk,
  // Instruction requests.
  output var logic [13:0] core_pc,
  output var logic core_store,
  output var logic [13:0] core_store_addr,
  output var logic [15:0] core_store_data,
  output var logic core_load,
  output var logic [13:0] core_load_addr,
  output var logic core_gie,
  output var logic core_vec_in_loader,
  // Answers from the guard.
  input wire logic store_done_r,
  input wire logic store_refused_r,
  input wire logic load_grant_r,
  input wire logic load_refused_r,
  input wire logic page_erase_r,
  input wire logic page_write_r,
  input wire logic pbuf_load_r
);
  // Idle values at time zero.
  initial begin
    core_pc = 14'h3800;
    core_store = 1'b0;
    core_store_addr = 14'h0;
    core_store_data = 16'h0;
    core_load = 1'b0;
    core_load_addr = 14'h0;
    core_gie = 1'b0;
    core_vec_in_loader = 1'b0;
  end
  // One store pulse; r collects {op started, done, refused} over the two answer cycles.
  // Operands are inverted afterwards so nothing can lean on stale values.
  task store(input logic [13:0] pc, input logic [13:0] a, input logic [15:0] d, output logic [2:0] r);
    core_pc <= pc;
    core_store_addr <= a;
    core_store_data <= d;
    core_store <= 1'b1;
    @(posedge clk);
    core_store <= 1'b0;
    core_store_addr <= ~a;
    core_store_data <= ~d;
    r = 3'b000;
    repeat (2) begin
      @(posedge clk);
      r = r | {page_erase_r | page_write_r | pbuf_load_r, store_done_r, store_refused_r};
    end
  endtask
  // One load pulse; r collects {0, grant, refused}.
  task load(input logic [13:0] pc, input logic [13:0] a, output logic [2:0] r);
    core_pc <= pc;
    core_load_addr <= a;
    core_load <= 1'b1;
    @(posedge clk);
    core_load <= 1'b0;
    core_load_addr <= ~a;
    r = 3'b000;
    repeat (2) begin
      @(posedge clk);
      r = r | {1'b0, load_grant_r, load_refused_r};
    end
  endtask
endmodule // sfg_core_model
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Register-level test of the flash guard with a behavioural core.
module tb_top;
  logic clk, rst_b, psel, penable, pwrite, ext_lock_we, ext_chip_erase, ext_loader_reset_fuse, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  logic [3:0] ext_lock_data;
  logic [2:0] r;
  wire [31:0] prdata;
  wire [13:0] core_pc, core_store_addr, core_load_addr, page_addr_r;
  wire [15:0] core_store_data;
  wire [12:0] reset_vector_r;
  wire pready, pslverr, core_store, core_load, core_gie, core_vec_in_loader, store_done_r, store_refused_r;
  wire load_grant_r, load_refused_r, cpu_halt_r, irq_req_r, irq_suppress_r, page_erase_r, page_write_r;
  wire pbuf_load_r, pbuf_discard_r, concurrent_section_busy_r;
  int failures, compares, discards;
  // Long enough that reads and writes fit inside one erase.
  sfg_top #(.PROG_CYCLES(16'h0018)) u_sfg_top (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .core_pc, .core_store, .core_store_addr, .core_store_data, .core_load,
    .core_load_addr, .core_gie, .core_vec_in_loader, .store_done_r, .store_refused_r, .load_grant_r,
    .load_refused_r, .cpu_halt_r, .irq_req_r, .irq_suppress_r, .reset_vector_r, .page_erase_r, .page_write_r,
    .page_addr_r, .pbuf_load_r, .pbuf_discard_r, .concurrent_section_busy_r, .ext_lock_we, .ext_lock_data,
    .ext_chip_erase, .ext_loader_reset_fuse);
  sfg_core_model u_core (.clk, .core_pc, .core_store, .core_store_addr, .core_store_data, .core_load,
    .core_load_addr, .core_gie, .core_vec_in_loader, .store_done_r, .store_refused_r, .load_grant_r,
    .load_refused_r, .page_erase_r, .page_write_r, .pbuf_load_r);
  // 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The discard is a one-cycle pulse, so discards are counted here.
  always @(posedge clk) begin
    if (rst_b !== 1'b1) discards <= 0;
    else if (pbuf_discard_r === 1'b1) discards <= discards + 1;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // APB transfer held until pready is sampled high; an idle edge precedes each setup.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) begin
      failures++;
      final_report;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("rdata", q, x);
  endtask
  // Bounded wait for the end of an erase or write.
  task wait_done;
    int n;
    n = 0;
    while (store_done_r !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      failures++;
      final_report;
    end
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, ext_lock_we, ext_chip_erase} = 6'h0;
    {paddr, pwdata, ext_lock_data} = 44'h0;
    ext_loader_reset_fuse = 1'b1;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk("vector", reset_vector_r, 32'h0);
    rdc(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    rdc(8'h08, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", e, 32'h1);
    wr(8'h00, 32'hFF);
    rdc(8'h00, 32'h80);
    u_core.core_gie <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq", irq_req_r, 32'h1);
    wr(8'h00, 32'h0);
    // Page load, arming lapse, store from application code.
    wr(8'h00, 32'h1);
    u_core.store(14'h3800, 14'h0010, 16'h1234, r);
    chk("pload", r, 32'h6);
    rdc(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    repeat (5) @(posedge clk);
    u_core.store(14'h3800, 14'h0010, 16'h1234, r);
    chk("lapse", r, 32'h0);
    wr(8'h00, 32'h1);
    u_core.store(14'h0000, 14'h0010, 16'h1234, r);
    chk("appstore", r, 32'h1);
    // Erase in the concurrent section, re-enable refused while running.
    wr(8'h00, 32'h3);
    u_core.store(14'h3800, 14'h0100, 16'h0, r);
    chk("erase", r, 32'h4);
    chk("pageaddr", page_addr_r, 32'h100);
    rdc(8'h00, 32'h43);
    wr(8'h00, 32'h11);
    rdc(8'h00, 32'h43);
    u_core.load(14'h3800, 14'h0100, r);
    chk("busyload", r, 32'h1);
    wait_done;
    rdc(8'h00, 32'h40);
    // The buffer still holds the first page load, so this re-enable drops it.
    wr(8'h00, 32'h11);
    u_core.store(14'h3800, 14'h0, 16'h0, r);
    chk("reenable", r, 32'h2);
    chk("discard1", discards, 32'h1);
    rdc(8'h00, 32'h0);
    // Page write, then a page load clears busy; re-enable drops the buffer.
    wr(8'h00, 32'h5);
    u_core.store(14'h3800, 14'h0200, 16'h0, r);
    chk("pwrite", r, 32'h4);
    wait_done;
    wr(8'h00, 32'h1);
    u_core.store(14'h3800, 14'h0210, 16'h5678, r);
    rdc(8'h00, 32'h0);
    wr(8'h00, 32'h11);
    repeat (6) @(posedge clk);
    chk("discard2", discards, 32'h2);
    // Erase in the halting section stops the core and leaves busy clear.
    wr(8'h00, 32'h3);
    u_core.store(14'h3800, 14'h3900, 16'h0, r);
    chk("halt", cpu_halt_r, 32'h1);
    wait_done;
    rdc(8'h00, 32'h0);
    // Lock fields set by software can only be programmed further.
    wr(8'h00, 32'h9);
    u_core.store(14'h3800, 14'h0, 16'h0038, r);
    rdc(8'h04, 32'hE);
    wr(8'h00, 32'h3);
    u_core.store(14'h3800, 14'h0100, 16'h0, r);
    chk("mode2", r, 32'h1);
    u_core.load(14'h3800, 14'h0100, r);
    chk("mode2ld", r, 32'h2);
    wr(8'h00, 32'h9);
    u_core.store(14'h3800, 14'h0, 16'h003C, r);
    rdc(8'h04, 32'hE);
    wr(8'h00, 32'h9);
    u_core.store(14'h3800, 14'h0, 16'h0030, r);
    u_core.load(14'h3800, 14'h0100, r);
    chk("mode3ld", r, 32'h1);
    u_core.core_vec_in_loader <= 1'b1;
    u_core.core_pc <= 14'h0;
    repeat (3) @(posedge clk);
    chk("appirq", irq_suppress_r, 32'h1);
    // Chip erase over the pins, then loader lock mode 3 from the pins.
    ext_chip_erase <= 1'b1;
    repeat (4) @(posedge clk);
    ext_chip_erase <= 1'b0;
    rdc(8'h04, 32'hF);
    ext_lock_data <= 4'h3;
    ext_lock_we <= 1'b1;
    repeat (4) @(posedge clk);
    ext_lock_we <= 1'b0;
    rdc(8'h04, 32'h3);
    u_core.load(14'h0, 14'h3900, r);
    chk("ldrld", r, 32'h1);
    u_core.load(14'h3800, 14'h3900, r);
    chk("sameld", r, 32'h2);
    u_core.load(14'h3800, 14'h0100, r);
    chk("mode1ld", r, 32'h2);
    wr(8'h00, 32'h3);
    u_core.store(14'h3800, 14'h3900, 16'h0, r);
    chk("ldrst", r, 32'h1);
    u_core.core_vec_in_loader <= 1'b0;
    u_core.core_pc <= 14'h3800;
    repeat (3) @(posedge clk);
    chk("ldrirq", irq_suppress_r, 32'h1);
    // Reset again with the loader reset fuse programmed.
    ext_loader_reset_fuse <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk("vector", reset_vector_r, 32'h1C00);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
